// [design/fp_ui_defines.svh]
// offsets, field positions, reset values and timing figures of the front panel controller
// assumes inclusion by bare name from the design files
`ifndef FP_UI_DEFINES_SVH
`define FP_UI_DEFINES_SVH

`define FP_CLK_HZ 50000000
// one timer tick per millisecond
`define FP_TICK_CYC (`FP_CLK_HZ / 1000)

`define FP_DEBOUNCE_MS 10
`define FP_HB_SLOW_MS 1000
`define FP_HB_FAST_MS 500
`define FP_STAGE1_MS 5000
`define FP_STAGE2_MS 10000
`define FP_WINDOW_MS 3000
`define FP_DARK_MS 1000
`define FP_AMBER_MS 3000
`define FP_SEQ_PRESSES 3

`define FP_REG_CTRL 4'h0
`define FP_REG_STATUS 4'h4
`define FP_CTRL_DYN_BIT 0
`define FP_CTRL_LOCK_BIT 1
`define FP_CTRL_RESET 32'h00000000

`endif

// [design/fp_ui_pkg.sv]
// types shared by the front panel controller, its port assertions and its bench
// assumes the defines header for all numeric figures
package fp_ui_pkg;

    typedef struct packed {
        logic powered;
        logic operating;
        logic bootloader;
        logic audio_present;
        logic audio_deembed;
        logic audio_mute;
        logic [1:0] auto_en;
    } unit_status_t;

    typedef struct packed {
        logic heartbeat;
        logic audio;
        logic [1:0] auto_sw;
        logic [7:0] xp_green;
        logic [7:0] xp_amber;
    } panel_led_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_HOLD = 3'b001,
        SEQ_STAGE1 = 3'b010,
        SEQ_STAGE2 = 3'b011,
        SEQ_WAIT1 = 3'b100,
        SEQ_WAIT2 = 3'b101,
        SEQ_REBOOT = 3'b110,
        SEQ_DARK = 3'b111
    } seq_state_t;

endpackage : fp_ui_pkg

// [design/button_debounce.sv]
// debouncer for a group of push buttons, one filter per button
// assumes raw levels synchronous to the clock and a one-cycle millisecond tick
`timescale 1ns/1ps
module button_debounce #(
    parameter int N = 3,
    parameter int STABLE_MS = 10
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_tick_ms,
    input wire logic [N-1:0] i_raw,
    output logic [N-1:0] o_clean
);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_btn
            logic [7:0] cnt_r;
            // RL18 stable level filter
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cnt_r <= 8'h00;
                    o_clean[g] <= 1'b0;
                end else if (i_raw[g] == o_clean[g]) begin
                    cnt_r <= 8'h00;
                end else if (i_tick_ms) begin
                    if (cnt_r == 8'(STABLE_MS - 1)) begin
                        cnt_r <= 8'h00;
                        o_clean[g] <= i_raw[g];
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
            end
        end
    endgenerate

endmodule : button_debounce

// [design/front_panel_ui_controller.sv]
// front panel controller: status and crosspoint leds, button decoding, long-press sequences
// assumes unit status and selections from the rest of the unit, buttons active high,
// and an Avalon-MM master for the control and status registers
//
// Notes on behaviour
// RL1: normal operation blinks heartbeat led with one second period.
// RL2: bootloader mode blinks heartbeat led fast, half second period.
// RL3: powered but not operating holds heartbeat led steadily lit.
// RL4: audio led off when no embedded audio or analog output muted.
// RL5: audio led blinks when embedded audio cannot be de-embedded.
// RL6: audio led steady when embedded audio is present and de-embedded.
// RL7: each output's auto-switch led follows its autoselect enable.
// RL8: selected input's crosspoint led steady when that input has signal.
// RL9: selected input's crosspoint led blinks green when input has no signal.
// RL10: chosen audio configuration shown by blinking amber crosspoint led of that number.
// RL11: each video button press requests next source for that output.
// RL12: each audio button press steps to next stored audio configuration.
// RL13: fixed address by default; dynamic addressing only by panel sequence or software.
// RL14: audio button held five seconds starts blinking all panel leds.
// RL15: after 5-10 s hold, three presses in 3 s: dark, dynamic address request.
// RL16: hold reaching ten seconds switches panel blinking to faster rate.
// RL17: after 10 s hold, three presses in 3 s: dark, factory restore, reboot.
// RL18: buttons are debounced before holds are timed or presses counted.
// RL19: too few presses within the window abandons the sequence silently.
// RL20: sequence presses never step the audio configuration.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fp_ui_defines.svh"
module front_panel_ui_controller
    import fp_ui_pkg::*;
#(
    parameter int TICK_CYC = `FP_TICK_CYC,
    parameter int DEBOUNCE_MS = `FP_DEBOUNCE_MS,
    parameter int STAGE1_MS = `FP_STAGE1_MS,
    parameter int STAGE2_MS = `FP_STAGE2_MS,
    parameter int WINDOW_MS = `FP_WINDOW_MS,
    parameter int DARK_MS = `FP_DARK_MS,
    parameter int AMBER_MS = `FP_AMBER_MS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire unit_status_t i_status,
    input wire logic [3:0] i_sel,
    input wire logic [3:0] i_sig_present,
    input wire logic i_btn_out1,
    input wire logic i_btn_out2,
    input wire logic i_btn_audio,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output panel_led_t o_leds,
    output logic [1:0] o_src_next,
    output logic [1:0] o_audio_cfg,
    output logic o_dyn_addr_en,
    output logic o_factory_req,
    output logic o_reboot_req
);

    localparam int HB_SLOW_HALF = `FP_HB_SLOW_MS / 2;
    localparam int HB_FAST_HALF = `FP_HB_FAST_MS / 2;

    logic [31:0] div_r;
    logic tick_r;
    logic [9:0] ms_r;
    logic blink_slow;
    logic blink_fast;
    logic [2:0] btn_db;
    logic [2:0] btn_prev_r;
    logic [2:0] btn_rise;
    logic audio_fall;
    seq_state_t seq_r;
    logic [13:0] tmr_r;
    logic [1:0] presses_r;
    logic [11:0] amber_r;
    logic lock_r;
    logic dyn_set;
    logic third_press;
    panel_led_t leds_nxt;
    logic bus_take;

    // free running millisecond tick; the slower rates all derive from it
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (div_r == 32'(TICK_CYC - 1)) begin
            div_r <= 32'h00000000;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 32'h00000001;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ms_r <= 10'h000;
        end else if (tick_r) begin
            ms_r <= (ms_r == 10'(`FP_HB_SLOW_MS - 1)) ? 10'h000 : ms_r + 10'h001;
        end
    end

    // RL1 one second period
    assign blink_slow = (ms_r < 10'(HB_SLOW_HALF));
    // RL2 half second period
    assign blink_fast = ((ms_r % 10'(`FP_HB_FAST_MS)) < 10'(HB_FAST_HALF));

    button_debounce #(
        .N(3),
        .STABLE_MS(DEBOUNCE_MS)
    ) u_debounce (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick_ms(tick_r),
        .i_raw({i_btn_audio, i_btn_out2, i_btn_out1}),
        .o_clean(btn_db)
    );

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            btn_prev_r <= 3'h0;
        end else begin
            btn_prev_r <= btn_db;
        end
    end

    // locked panel or non-operating unit ignores every new button press
    assign btn_rise = (lock_r || !i_status.operating) ? 3'h0 : (btn_db & ~btn_prev_r);
    assign audio_fall = btn_prev_r[2] & ~btn_db[2];
    assign third_press = btn_rise[2] && (presses_r == 2'(`FP_SEQ_PRESSES - 1));

    // RL11 next source per output
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_src_next <= 2'h0;
        end else begin
            o_src_next <= btn_rise[1:0];
        end
    end

    // audio button sequence; the timer restarts on every state change except hold to stage one, where it keeps counting
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_r <= SEQ_IDLE;
            tmr_r <= 14'h0000;
            presses_r <= 2'h0;
        end else begin
            unique case (seq_r)
                SEQ_IDLE: begin
                    tmr_r <= 14'h0000;
                    presses_r <= 2'h0;
                    if (btn_rise[2]) begin
                        seq_r <= SEQ_HOLD;
                    end
                end
                SEQ_HOLD, SEQ_STAGE1: begin
                    if (tick_r) begin
                        tmr_r <= tmr_r + 14'h0001;
                    end
                    if (audio_fall) begin
                        seq_r <= (seq_r == SEQ_HOLD) ? SEQ_IDLE : SEQ_WAIT1;
                        tmr_r <= 14'h0000;
                    // RL14 five second stage
                    end else if (seq_r == SEQ_HOLD && tmr_r == 14'(STAGE1_MS)) begin
                        seq_r <= SEQ_STAGE1;
                    // RL16 ten second stage
                    end else if (seq_r == SEQ_STAGE1 && tmr_r == 14'(STAGE2_MS)) begin
                        seq_r <= SEQ_STAGE2;
                    end
                end
                SEQ_STAGE2: begin
                    tmr_r <= 14'h0000;
                    if (audio_fall) begin
                        seq_r <= SEQ_WAIT2;
                    end
                end
                SEQ_WAIT1, SEQ_WAIT2: begin
                    if (tick_r) begin
                        tmr_r <= tmr_r + 14'h0001;
                    end
                    // RL15 third press in window
                    if (third_press) begin
                        seq_r <= (seq_r == SEQ_WAIT1) ? SEQ_DARK : SEQ_REBOOT;
                        tmr_r <= 14'h0000;
                    end else if (btn_rise[2]) begin
                        presses_r <= presses_r + 2'h1;
                    // RL19 window expired, abandon
                    end else if (tmr_r == 14'(WINDOW_MS)) begin
                        seq_r <= SEQ_IDLE;
                    end
                end
                SEQ_REBOOT: begin
                    seq_r <= SEQ_DARK;
                end
                SEQ_DARK: begin
                    if (tick_r) begin
                        tmr_r <= tmr_r + 14'h0001;
                    end
                    if (tmr_r == 14'(DARK_MS)) begin
                        seq_r <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // RL12 RL20 short press released before stage one steps the preset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_audio_cfg <= 2'h0;
            amber_r <= 12'h000;
        end else if (seq_r == SEQ_HOLD && audio_fall) begin
            o_audio_cfg <= o_audio_cfg + 2'h1;
            amber_r <= 12'(AMBER_MS);
        end else if (tick_r && amber_r != 12'h000) begin
            amber_r <= amber_r - 12'h001;
        end
    end

    // RL17 factory restore then reboot one cycle later
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_factory_req <= 1'b0;
            o_reboot_req <= 1'b0;
        end else begin
            o_factory_req <= (seq_r == SEQ_WAIT2) && third_press;
            o_reboot_req <= (seq_r == SEQ_REBOOT);
        end
    end

    assign dyn_set = (seq_r == SEQ_WAIT1) && third_press;
    assign bus_take = !o_avs_waitrequest;

    // RL13 fixed address at reset; set by panel wins over a software clear
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dyn_addr_en <= 1'(`FP_CTRL_RESET);
            lock_r <= 1'b0;
        end else begin
            if (bus_take && i_avs_write && i_avs_address == `FP_REG_CTRL) begin
                o_dyn_addr_en <= i_avs_writedata[`FP_CTRL_DYN_BIT] | dyn_set;
                lock_r <= i_avs_writedata[`FP_CTRL_LOCK_BIT];
            end else if (dyn_set) begin
                o_dyn_addr_en <= 1'b1;
            end
        end
    end

    // one wait state per access keeps every bus output registered
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                unique case (i_avs_address)
                    `FP_REG_CTRL: o_avs_readdata <= {30'h0, lock_r, o_dyn_addr_en};
                    `FP_REG_STATUS: o_avs_readdata <= {24'h0, btn_db, seq_r, o_audio_cfg};
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_comb begin
        leds_nxt = '0;
        // RL3 steady when powered but idle
        leds_nxt.heartbeat = i_status.powered;
        if (i_status.bootloader) begin
            // RL2 fast heartbeat
            leds_nxt.heartbeat = blink_fast;
        end else if (i_status.operating) begin
            // RL1 slow heartbeat
            leds_nxt.heartbeat = blink_slow;
        end
        // RL4 RL5 RL6 audio indicator
        if (i_status.audio_present && !i_status.audio_mute) begin
            leds_nxt.audio = i_status.audio_deembed ? 1'b1 : blink_slow;
        end
        // RL7 auto-switch flags
        leds_nxt.auto_sw = i_status.auto_en;
        for (int o = 0; o < 2; o++) begin
            // RL8 RL9 steady or blinking green
            if (i_sig_present[i_sel[2*o +: 2]]) begin
                leds_nxt.xp_green[4*o + int'(i_sel[2*o +: 2])] = 1'b1;
            end else begin
                leds_nxt.xp_green[4*o + int'(i_sel[2*o +: 2])] = blink_slow;
            end
        end
        // RL10 amber shows preset number on the first row
        if (amber_r != 12'h000) begin
            leds_nxt.xp_green[3:0] = 4'h0;
            leds_nxt.xp_amber[int'(o_audio_cfg)] = blink_slow;
        end
        if (i_status.bootloader || !i_status.operating) begin
            leds_nxt.audio = 1'b0;
            leds_nxt.auto_sw = 2'h0;
            leds_nxt.xp_green = 8'h00;
            leds_nxt.xp_amber = 8'h00;
        end
        // RL14 RL16 whole panel blinks during the long press stages
        if (seq_r == SEQ_STAGE1 || seq_r == SEQ_WAIT1) begin
            leds_nxt = blink_slow ? '1 : '0;
        end else if (seq_r == SEQ_STAGE2 || seq_r == SEQ_WAIT2) begin
            leds_nxt = blink_fast ? '1 : '0;
        end else if (seq_r == SEQ_DARK || seq_r == SEQ_REBOOT) begin
            // RL15 RL17 dark after success
            leds_nxt = '0;
        end
        // RL1 RL3 dark without power
        if (!i_status.powered) begin
            leds_nxt = '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_leds <= '0;
        end else begin
            o_leds <= leds_nxt;
        end
    end

endmodule : front_panel_ui_controller

// [testbench/fp_button_model.sv]
// front panel push button with contact bounce, worked by the bench through its tasks
// assumes the system clock of the controller; high means pressed
`timescale 1ns/1ps
module fp_button_model (
    input wire logic i_clk_sys,
    output logic o_btn
);
    initial o_btn = 1'b0;
    // a one-cycle bounce must never count as a press
    task down();
        @(posedge i_clk_sys) o_btn <= 1'b1;
        @(posedge i_clk_sys) o_btn <= 1'b0;
        @(posedge i_clk_sys) o_btn <= 1'b1;
    endtask : down
    task up();
        @(posedge i_clk_sys) o_btn <= 1'b0;
    endtask : up
    task tap(input int hi, input int lo);
        down();
        repeat (hi) @(posedge i_clk_sys);
        up();
        repeat (lo) @(posedge i_clk_sys);
    endtask : tap
endmodule : fp_button_model

// [testbench/front_panel_ui_controller_chk.sv]
// port assertions for the front panel controller, bound into the design
// assumes the bench holds status steady while it works the buttons
`timescale 1ns/1ps
module front_panel_ui_controller_chk
    import fp_ui_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire unit_status_t i_status,
    input wire logic [3:0] i_sel,
    input wire logic [3:0] i_sig_present,
    input wire logic i_btn_out1,
    input wire logic i_btn_out2,
    input wire logic i_btn_audio,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire panel_led_t o_leds,
    input wire logic [1:0] o_src_next,
    input wire logic o_dyn_addr_en,
    input wire logic o_factory_req,
    input wire logic o_reboot_req
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] quiet_r;
    logic calm, hb_on_w, aud_off_w, lit_w;
    logic [1:0] sel_w;
    // sequences and preset display overlay the status leds, so judge only when buttons rest
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            quiet_r <= 8'h00;
        end else if (i_btn_out1 | i_btn_out2 | i_btn_audio) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hFF) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end
    assign calm = (quiet_r > 8'hC8) && i_status.powered && i_status.operating
        && !i_status.bootloader;
    assign hb_on_w = i_status.powered && !i_status.operating && !i_status.bootloader;
    assign aud_off_w = calm && (!i_status.audio_present || i_status.audio_mute);
    assign lit_w = calm && i_sig_present[i_sel[1:0]];
    assign sel_w = i_sel[1:0];
    wait_one_a: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus answer not one cycle after request");
    wait_back_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    reboot_next_a: assert property (o_factory_req |=> o_reboot_req && !o_factory_req)
        else $error("reboot request did not follow factory request");
    reboot_cause_a: assert property (o_reboot_req |-> $past(o_factory_req))
        else $error("reboot request without factory request");
    src_pulse_a: assert property (o_src_next != 2'h0
        |=> (o_src_next & $past(o_src_next)) == 2'h0)
        else $error("source request longer than one cycle");
    auto_led_a: assert property ($past(calm) |-> o_leds.auto_sw == $past(i_status.auto_en))
        else $error("auto switch leds differ from enables");
    heartbeat_led_off_a: assert property ($past(!i_status.powered) |-> !o_leds.heartbeat)
        else $error("heartbeat lit without power");
    heartbeat_led_steady_a: assert property ($past(hb_on_w) |-> o_leds.heartbeat)
        else $error("heartbeat not steady when idle");
    audio_off_a: assert property ($past(aud_off_w) |-> !o_leds.audio)
        else $error("audio led lit without audio");
    xp_lit_a: assert property ($past(lit_w) |-> o_leds.xp_green[$past(sel_w)])
        else $error("selected crosspoint led dark with signal");
    cover property (o_factory_req);
    cover property ($rose(o_dyn_addr_en));
    cover property (i_avs_write && !o_avs_waitrequest);
    cover property (o_src_next[1]);
endmodule : front_panel_ui_controller_chk
bind front_panel_ui_controller front_panel_ui_controller_chk u_chk (.i_clk_sys, .i_rst_n,
    .i_status, .i_sel, .i_sig_present, .i_btn_out1, .i_btn_out2, .i_btn_audio, .i_avs_read,
    .i_avs_write, .o_avs_waitrequest, .o_leds, .o_src_next, .o_dyn_addr_en, .o_factory_req,
    .o_reboot_req);

// [testbench/tb_front_panel_ui_controller.sv]
// self-checking bench for the front panel controller: bus, leds, buttons, sequences
// assumes shortened timing parameters; one millisecond is two clock cycles
`timescale 1ns/1ps
module tb_front_panel_ui_controller;
    import fp_ui_pkg::*;
    logic i_clk_sys, i_rst_n, i_avs_read, i_avs_write, b1, b2, ba, wreq, dyn, fac, rbt, h;
    unit_status_t st;
    logic [3:0] sel, sigp, addr;
    logic [31:0] wdata, rdata, q, rnd;
    panel_led_t leds;
    logic [1:0] src, cfg, e;
    logic [2:0] hag;
    int errors = 0, total_checks = 0, n_src1 = 0, n_src2 = 0, n_fac = 0, n_rbt = 0, cyc = 0;
    front_panel_ui_controller #(.TICK_CYC(2), .DEBOUNCE_MS(2), .STAGE1_MS(20),
        .STAGE2_MS(40), .WINDOW_MS(30), .DARK_MS(5), .AMBER_MS(10)) u_dut (
        .i_clk_sys, .i_rst_n, .i_status(st), .i_sel(sel), .i_sig_present(sigp),
        .i_btn_out1(b1), .i_btn_out2(b2), .i_btn_audio(ba), .i_avs_address(addr),
        .i_avs_read, .i_avs_write, .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_leds(leds), .o_src_next(src), .o_audio_cfg(cfg),
        .o_dyn_addr_en(dyn), .o_factory_req(fac), .o_reboot_req(rbt));
    fp_button_model u_b1 (.i_clk_sys, .o_btn(b1));
    fp_button_model u_b2 (.i_clk_sys, .o_btn(b2));
    fp_button_model u_ba (.i_clk_sys, .o_btn(ba));
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        n_src1 <= n_src1 + int'(src[0]);
        n_src2 <= n_src2 + int'(src[1]);
        n_fac <= n_fac + int'(fac);
        n_rbt <= n_rbt + int'(rbt);
        cyc <= i_rst_n ? cyc + 1 : 0;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_sim();
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
        @(posedge i_clk_sys);
        addr <= ad;
        wdata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        // only the watchdog ends an answer that never comes
        while (wreq !== 1'b0) @(posedge i_clk_sys);
        q = rdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus
    initial begin
        #1000000;
        errors++;
        end_sim();
    end
    initial begin
        {i_rst_n, i_avs_read, i_avs_write} = 3'h0;
        {st, sel, sigp, addr, wdata} = {8'hC0, 4'h0, 4'hF, 4'h0, 32'h0};
        rnd = 32'h311DC6E3;
        repeat (2) @(posedge i_clk_sys);
        // leds follow status from the first free edge on, so look while reset still holds
        chk("reset outputs", {leds, src, cfg, dyn, fac, rbt, wreq}, 32'h1);
        i_rst_n <= 1'b1;
        rnd = xs(rnd);
        bus(1'b1, 4'h0, {rnd[31:2], 2'b01});
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl readback", q, 32'h1);
        chk("dyn by bus", dyn, 1'b1);
        bus(1'b0, {1'b1, rnd[2:0]}, 32'h0);
        chk("unmapped read", q, 32'h0);
        bus(1'b1, 4'h0, {rnd[31:2], 2'b10});
        u_b1.tap(20, 20);
        chk("locked press", n_src1, 0);
        bus(1'b1, 4'h0, {rnd[31:2], 2'b00});
        bus(1'b0, 4'h4, 32'h0);
        chk("status idle", q, 32'h0);
        st <= 8'hD0;
        sigp <= 4'h0;
        repeat (5) @(posedge i_clk_sys);
        hag = ~{leds.heartbeat, leds.audio, leds.xp_green[0]};
        repeat (1000) @(posedge i_clk_sys);
        chk("slow blink", {leds.heartbeat, leds.audio, leds.xp_green[0]}, hag);
        st <= 8'h00;
        repeat (3) @(posedge i_clk_sys);
        st <= 8'hA0;
        repeat (5) @(posedge i_clk_sys);
        h = leds.heartbeat;
        repeat (500) @(posedge i_clk_sys);
        chk("fast blink", leds.heartbeat, !h);
        st <= 8'h80;
        repeat (700) @(posedge i_clk_sys);
        chk("steady heartbeat_led", leds.heartbeat, 1'b1);
        for (int i = 0; i < 12; i++) begin
            rnd = xs(rnd);
            st <= {3'b110, rnd[2:0], rnd[4:3]};
            sel <= rnd[8:5];
            sigp <= rnd[12:9];
            repeat (3) @(posedge i_clk_sys);
            chk("auto leds", leds.auto_sw, rnd[4:3]);
            if (!rnd[2] || rnd[0]) chk("audio off", leds.audio, 1'b0);
            else if (rnd[1]) chk("audio on", leds.audio, 1'b1);
            if (sigp[sel[1:0]]) chk("xp out1", leds.xp_green[sel[1:0]], 1'b1);
            if (sigp[sel[3:2]]) chk("xp out2", leds.xp_green[4 + sel[3:2]], 1'b1);
        end
        st <= 8'hC0;
        for (int k = 1; k <= 3; k++) begin
            u_b1.tap(12, 12);
            u_b2.tap(12, 12);
            chk("out1 steps", n_src1, k);
            chk("out2 steps", n_src2, k);
        end
        // amber blinks at the slow rate: run the presets early in its lit half (first 1000 of each 2000 cycles)
        while (cyc % 2000 != 100) @(posedge i_clk_sys);
        for (int k = 1; k <= 5; k++) begin
            e = 2'(k);
            u_ba.tap(12, 10);
            chk("preset", cfg, e);
            chk("amber row", leds.xp_amber, 8'h01 << e);
        end
        u_ba.down();
        repeat (60) @(posedge i_clk_sys);
        u_ba.up();
        repeat (6) @(posedge i_clk_sys);
        u_ba.tap(8, 90);
        bus(1'b0, 4'h4, 32'h0);
        chk("abandoned", {dyn, q[4:0]}, {4'h0, e});
        for (int k = 0; k < 2; k++) begin
            u_ba.down();
            repeat (60 + 40 * k) @(posedge i_clk_sys);
            bus(1'b0, 4'h4, 32'h0);
            chk("hold stage", q[4:2], 3'h2 + 3'(k));
            u_ba.up();
            repeat (6) @(posedge i_clk_sys);
            u_ba.tap(6, 5);
            u_ba.tap(6, 5);
            u_ba.down();
            repeat (9) @(posedge i_clk_sys);
            chk("dark panel", leds, 20'h0);
            if (k == 0) chk("dyn by panel", dyn, 1'b1);
            u_ba.up();
            repeat (40) @(posedge i_clk_sys);
        end
        chk("factory and reboot", {n_fac[15:0], n_rbt[15:0]}, 32'h00010001);
        chk("preset kept", cfg, e);
        end_sim();
    end
endmodule : tb_front_panel_ui_controller
